// ---- design/mcx_params.svh ----
`ifndef MCX_PARAMS_SVH
`define MCX_PARAMS_SVH

`define MCX_PC_W        11
`define MCX_IW          16
`define MCX_DW          8
`define MCX_PH_W        2
`define MCX_PH_STEP     2'h1
`define MCX_PH_FETCH    2'h1
`define MCX_PH_READ     2'h2
`define MCX_PH_EXEC     2'h3
`define MCX_CLK_PER_IC  4
`define MCX_OP_HI       15
`define MCX_OP_LO       11
`define MCX_BIT_HI      10
`define MCX_BIT_LO      8
`define MCX_ROT_HI      10
`define MCX_ROT_LO      9
`define MCX_TGT_HI      10
`define MCX_F_IMM       9
`define MCX_F_MEM       8
`define MCX_M_HI        7
`define MCX_PC_LOW_ADDR 8'h02
`define MCX_PC_INC      11'h001
`define MCX_PC_INC2     11'h002
`define MCX_BIT_ONE     8'h01
`define MCX_WAKE_SYNC   3

`endif

// ---- design/mcx_pkg.sv ----
`include "mcx_params.svh"
package mcx_pkg;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_XFER_AM  = 5'h01,
    OP_XFER_MA  = 5'h02,
    OP_XFER_AX  = 5'h03,
    OP_ADD      = 5'h04,
    OP_ADC      = 5'h05,
    OP_SUB      = 5'h06,
    OP_SBC      = 5'h07,
    OP_AND      = 5'h0a,
    OP_OR       = 5'h0b,
    OP_XOR      = 5'h0c,
    OP_COMPL    = 5'h0d,
    OP_INC      = 5'h0e,
    OP_DEC      = 5'h0f,
    OP_ROT      = 5'h10,
    OP_CLRB     = 5'h11,
    OP_SETB     = 5'h12,
    OP_SZ       = 5'h13,
    OP_SZA      = 5'h14,
    OP_SZB      = 5'h15,
    OP_SNZB     = 5'h16,
    OP_SIZ      = 5'h17,
    OP_SDZ      = 5'h18,
    OP_JUMP     = 5'h19,
    OP_CALL     = 5'h1a,
    OP_SUB_EXIT = 5'h1b,
    OP_INT_EXIT = 5'h1c,
    OP_TABRD    = 5'h1d,
    OP_HALT     = 5'h1e,
    OP_CLRWDT   = 5'h1f
  } mcx_op_t;

  typedef enum logic [3:0] {
    ALU_PASS   = 4'h0,
    ALU_ADD    = 4'h1,
    ALU_SUB    = 4'h2,
    ALU_AND    = 4'h3,
    ALU_OR     = 4'h4,
    ALU_XOR    = 4'h5,
    ALU_COMPL  = 4'h6,
    ALU_INC    = 4'h7,
    ALU_DEC    = 4'h8,
    ALU_ROT_R  = 4'h9,
    ALU_ROT_L  = 4'ha,
    ALU_ROT_RC = 4'hb,
    ALU_ROT_LC = 4'hc
  } mcx_alu_op_t;

  typedef struct packed {
    mcx_alu_op_t         op;
    logic [`MCX_DW-1:0]  a;
    logic [`MCX_DW-1:0]  b;
    logic                cin;
  } mcx_alu_in_t;

  typedef struct packed {
    logic [`MCX_DW-1:0]  y;
    logic                c;
    logic                z;
    logic                upd_c;
    logic                upd_z;
  } mcx_alu_out_t;

  typedef struct packed {
    logic [`MCX_DW-1:0]  addr;
    logic [`MCX_DW-1:0]  wdata;
    logic                we;
  } mcx_dm_req_t;

endpackage

// ---- design/mcx_alu.sv ----
`timescale 1ns/1ps
`include "mcx_params.svh"
module mcx_alu
  import mcx_pkg::*;
(
  input  wire mcx_alu_in_t  i_in,
  output      mcx_alu_out_t o_out
);

  logic [`MCX_DW:0] sum;

  always_comb
  begin
    sum   = '0;
    o_out = '0;
    case (i_in.op)
      ALU_ADD:
      begin
        sum = {1'b0, i_in.a} + {1'b0, i_in.b}
            + {{`MCX_DW{1'b0}}, i_in.cin};
        o_out.c     = sum[`MCX_DW];
        o_out.upd_c = 1'b1;
      end
      ALU_SUB:
      begin
        sum = {1'b0, i_in.a} - {1'b0, i_in.b}
            - {{`MCX_DW{1'b0}}, i_in.cin};
        // carry low marks a borrow
        o_out.c     = ~sum[`MCX_DW];
        o_out.upd_c = 1'b1;
      end
      ALU_AND:   sum[`MCX_DW-1:0] = i_in.a & i_in.b;
      ALU_OR:    sum[`MCX_DW-1:0] = i_in.a | i_in.b;
      ALU_XOR:   sum[`MCX_DW-1:0] = i_in.a ^ i_in.b;
      ALU_COMPL: sum[`MCX_DW-1:0] = ~i_in.a;
      ALU_INC:   sum[`MCX_DW-1:0] = i_in.a + `MCX_BIT_ONE;
      ALU_DEC:   sum[`MCX_DW-1:0] = i_in.a - `MCX_BIT_ONE;
      ALU_ROT_R: sum[`MCX_DW-1:0] = {i_in.a[0], i_in.a[`MCX_DW-1:1]};
      ALU_ROT_L: sum[`MCX_DW-1:0] = {i_in.a[`MCX_DW-2:0], i_in.a[`MCX_DW-1]};
      ALU_ROT_RC:
      begin
        sum[`MCX_DW-1:0] = {i_in.cin, i_in.a[`MCX_DW-1:1]};
        o_out.c     = i_in.a[0];
        o_out.upd_c = 1'b1;
      end
      ALU_ROT_LC:
      begin
        sum[`MCX_DW-1:0] = {i_in.a[`MCX_DW-2:0], i_in.cin};
        o_out.c     = i_in.a[`MCX_DW-1];
        o_out.upd_c = 1'b1;
      end
      default:   sum[`MCX_DW-1:0] = i_in.a;
    endcase
    o_out.y     = sum[`MCX_DW-1:0];
    o_out.z     = ~|sum[`MCX_DW-1:0];
    o_out.upd_z = !(i_in.op inside {ALU_PASS, ALU_ROT_R, ALU_ROT_L,
                                    ALU_ROT_RC, ALU_ROT_LC});
  end

endmodule

// ---- design/mcx_core.sv ----
`timescale 1ns/1ps
`include "mcx_params.svh"
// Notes on behaviour
// - most instructions finish in one instruction cycle
// - jump, call, both returns and table read take two cycles
// - one instruction cycle is exactly four system clocks
// - writing the program counter low byte costs one extra cycle
// - a taken skip costs one extra cycle, untaken skip costs none
// - moves: memory to acc, acc to memory, immediate to acc
// - add carries above 255, subtract flags borrow below zero
// - increment and decrement change by one, result to memory or acc
// - logic results set zero flag when zero, clear it otherwise
// - two-operand arithmetic and logic take the accumulator as one operand; complement, inc, dec and rotate use memory
// - rotates shift one bit; through-carry forms swap bit and carry
// - jump loads the target without saving a return address
// - call saves the next address; return resumes there
// - skips test a memory byte or one bit of it
// - bit set and clear change only the chosen bit
// - table read fetches program memory data into data memory
// - power-down and watchdog control instructions exist
// - interrupt exit sets global interrupt enable; plain exit leaves it
// - only the program counter goes onto the return stack
module mcx_core
  import mcx_pkg::*;
#(
  parameter int STACK_D = 8
) (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_ARST_N,
  input  wire logic [`MCX_IW-1:0]   I_PM_DATA,
  input  wire logic [`MCX_DW-1:0]   I_DM_RDATA,
  input  wire logic                 I_WAKE,
  output      logic [`MCX_PC_W-1:0] O_PM_ADDR,
  output      mcx_dm_req_t          O_DM,
  output      logic [`MCX_DW-1:0]   O_ACC,
  output      logic [`MCX_DW-1:0]   O_TBLH,
  output      logic                 O_ZERO,
  output      logic                 O_CARRY,
  output      logic                 O_GIE,
  output      logic                 O_PDOWN,
  output      logic                 O_WDT_CLR,
  output      logic                 O_ICYC
);

  localparam int SP_W = (STACK_D > 1) ? $clog2(STACK_D) : 1;

  if (STACK_D < 2 || (STACK_D & (STACK_D - 1)) != 0)
  begin : g_bad_depth
    $error("STACK_D must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [`MCX_PH_W-1:0]              ph;
    logic [`MCX_PC_W-1:0]              pc;
    logic [`MCX_PC_W-1:0]              pma;
    logic [`MCX_IW-1:0]                ir;
    logic [`MCX_IW-1:0]                tw;
    logic [`MCX_DW-1:0]                md;
    logic [`MCX_DW-1:0]                acc;
    logic [`MCX_DW-1:0]                tblh;
    logic [`MCX_DW-1:0]                dwd;
    logic                              dwe;
    logic                              z;
    logic                              c;
    logic                              gie;
    logic                              stall;
    logic                              tab;
    logic                              pd;
    logic                              wdt;
    logic [`MCX_WAKE_SYNC-1:0]         wk;
    logic [SP_W-1:0]                   sp;
    logic [STACK_D-1:0][`MCX_PC_W-1:0] stk;
  } mcx_core_st_t;

  mcx_core_st_t         s_q;
  mcx_core_st_t         s_d;
  mcx_op_t              op;
  mcx_alu_in_t          ain;
  mcx_alu_out_t         aout;
  logic [`MCX_DW-1:0]   imm;
  logic [`MCX_DW-1:0]   bit_mask;
  logic [`MCX_DW-1:0]   wr_v;
  logic [`MCX_PC_W-1:0] pc_inc;
  logic [`MCX_PC_W-1:0] top_ret;
  logic [`MCX_PC_W-1:0] tab_addr;
  logic [SP_W-1:0]      sp_dec;
  logic                 wr_en;
  logic                 skip;
  logic                 to_mem;
  logic                 imm_sel;
  logic                 wake_hi;
  logic                 ex;

  function automatic logic uses_alu(input mcx_op_t f_op);
    uses_alu = f_op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR,
                            OP_XOR, OP_COMPL, OP_INC, OP_DEC, OP_ROT,
                            OP_SIZ, OP_SDZ};
  endfunction

  function automatic logic is_skip(input mcx_op_t f_op);
    is_skip = f_op inside {OP_SZ, OP_SZA, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ};
  endfunction

  function automatic mcx_alu_op_t rot_op(input logic [1:0] kind);
    case (kind)
      2'h0:    rot_op = ALU_ROT_R;
      2'h1:    rot_op = ALU_ROT_L;
      2'h2:    rot_op = ALU_ROT_RC;
      default: rot_op = ALU_ROT_LC;
    endcase
  endfunction

  assign op       = mcx_op_t'(s_q.ir[`MCX_OP_HI:`MCX_OP_LO]);
  assign imm      = s_q.ir[`MCX_M_HI:0];
  assign imm_sel  = s_q.ir[`MCX_F_IMM];
  // rotates take no immediate: their kind field overlaps the immediate flag
  assign to_mem   = s_q.ir[`MCX_F_MEM] & (~imm_sel | op == OP_ROT);
  assign bit_mask = `MCX_BIT_ONE << s_q.ir[`MCX_BIT_HI:`MCX_BIT_LO];
  assign pc_inc   = s_q.pc + `MCX_PC_INC;
  assign sp_dec   = s_q.sp - 1'b1;
  assign top_ret  = s_q.stk[sp_dec];
  assign tab_addr = {s_q.pc[`MCX_PC_W-1:`MCX_DW], s_q.acc};
  assign wake_hi  = s_q.wk[1] & s_q.wk[2];
  assign ex       = !s_q.pd && s_q.ph == `MCX_PH_EXEC && !s_q.stall;

  // operand selection: accumulator is one side of two-operand ops; complement, inc, dec, rotate take memory
  always_comb
  begin
    ain     = '0;
    ain.a   = s_q.acc;
    ain.b   = imm_sel ? imm : s_q.md;
    ain.op  = ALU_PASS;
    case (op)
      OP_ADD:  ain.op = ALU_ADD;
      OP_SUB:  ain.op = ALU_SUB;
      OP_ADC:
      begin
        ain.op  = ALU_ADD;
        ain.cin = s_q.c;
      end
      OP_SBC:
      begin
        ain.op  = ALU_SUB;
        ain.cin = ~s_q.c;
      end
      OP_AND:  ain.op = ALU_AND;
      OP_OR:   ain.op = ALU_OR;
      OP_XOR:  ain.op = ALU_XOR;
      OP_COMPL:
      begin
        ain.op = ALU_COMPL;
        ain.a  = s_q.md;
      end
      OP_INC, OP_SIZ:
      begin
        ain.op = ALU_INC;
        ain.a  = s_q.md;
      end
      OP_DEC, OP_SDZ:
      begin
        ain.op = ALU_DEC;
        ain.a  = s_q.md;
      end
      OP_ROT:
      begin
        ain.op  = rot_op(s_q.ir[`MCX_ROT_HI:`MCX_ROT_LO]);
        ain.a   = s_q.md;
        ain.cin = s_q.c;
      end
      default: ain.op = ALU_PASS;
    endcase
  end

  mcx_alu u_alu (
    .i_in  (ain),
    .o_out (aout)
  );

  always_comb
  begin
    s_d    = s_q;
    wr_en  = 1'b0;
    wr_v   = '0;
    skip   = 1'b0;
    s_d.dwe = 1'b0;
    s_d.wdt = 1'b0;
    s_d.wk  = {s_q.wk[1:0], I_WAKE};
    if (s_q.pd)
    begin
      if (wake_hi)
        s_d.pd = 1'b0;
    end
    else
    begin
      s_d.ph = s_q.ph + `MCX_PH_STEP;
      case (s_q.ph)
        `MCX_PH_FETCH:
        begin
          // second cycles keep the instruction; fetch feeds tables only
          if (!s_q.stall)
            s_d.ir = I_PM_DATA;
          else
            s_d.tw = I_PM_DATA;
        end
        `MCX_PH_READ:
          s_d.md = I_DM_RDATA;
        `MCX_PH_EXEC:
        begin
          s_d.pc = pc_inc;
          if (s_q.stall)
          begin
            s_d.pc    = s_q.pc;
            s_d.stall = 1'b0;
            s_d.tab   = 1'b0;
            if (s_q.tab)
            begin
              wr_en    = 1'b1;
              wr_v     = s_q.tw[`MCX_DW-1:0];
              s_d.tblh = s_q.tw[`MCX_IW-1:`MCX_DW];
            end
          end
          else
          begin
            case (op)
              OP_XFER_AM: s_d.acc = s_q.md;
              OP_XFER_AX: s_d.acc = imm;
              OP_XFER_MA:
              begin
                wr_en = 1'b1;
                wr_v  = s_q.acc;
              end
              OP_CLRB:
              begin
                wr_en = 1'b1;
                wr_v  = s_q.md & ~bit_mask;
              end
              OP_SETB:
              begin
                wr_en = 1'b1;
                wr_v  = s_q.md | bit_mask;
              end
              OP_SZ:   skip = ~|s_q.md;
              OP_SZA:
              begin
                s_d.acc = s_q.md;
                skip    = ~|s_q.md;
              end
              OP_SZB:  skip = ~|(s_q.md & bit_mask);
              OP_SNZB: skip = |(s_q.md & bit_mask);
              OP_SIZ, OP_SDZ: skip = aout.z;
              OP_JUMP:
              begin
                s_d.pc    = s_q.ir[`MCX_TGT_HI:0];
                s_d.stall = 1'b1;
              end
              OP_CALL:
              begin
                s_d.stk[s_q.sp] = pc_inc;
                s_d.sp          = s_q.sp + 1'b1;
                s_d.pc          = s_q.ir[`MCX_TGT_HI:0];
                s_d.stall       = 1'b1;
              end
              OP_SUB_EXIT:
              begin
                s_d.pc    = top_ret;
                s_d.sp    = sp_dec;
                s_d.stall = 1'b1;
              end
              OP_INT_EXIT:
              begin
                s_d.pc    = top_ret;
                s_d.sp    = sp_dec;
                s_d.gie   = 1'b1;
                s_d.stall = 1'b1;
              end
              OP_TABRD:
              begin
                s_d.tab   = 1'b1;
                s_d.stall = 1'b1;
              end
              OP_HALT:   s_d.pd  = 1'b1;
              OP_CLRWDT: s_d.wdt = 1'b1;
              default: ;
            endcase
            if (uses_alu(op))
            begin
              if (to_mem)
              begin
                wr_en = 1'b1;
                wr_v  = aout.y;
              end
              else
                s_d.acc = aout.y;
              if (aout.upd_z && !is_skip(op))
                s_d.z = aout.z;
              if (aout.upd_c)
                s_d.c = aout.c;
            end
            if (skip)
            begin
              s_d.pc    = s_q.pc + `MCX_PC_INC2;
              s_d.stall = 1'b1;
            end
          end
          if (wr_en)
          begin
            // writes to the low pc byte redirect flow instead
            if (imm == `MCX_PC_LOW_ADDR)
            begin
              s_d.pc[`MCX_DW-1:0] = wr_v;
              s_d.stall           = 1'b1;
            end
            else
            begin
              s_d.dwe = 1'b1;
              s_d.dwd = wr_v;
            end
          end
          s_d.pma = s_d.tab ? tab_addr : s_d.pc;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign O_PM_ADDR   = s_q.pma;
  assign O_DM.addr   = imm;
  assign O_DM.wdata  = s_q.dwd;
  assign O_DM.we     = s_q.dwe;
  assign O_ACC       = s_q.acc;
  assign O_TBLH      = s_q.tblh;
  assign O_ZERO      = s_q.z;
  assign O_CARRY     = s_q.c;
  assign O_GIE       = s_q.gie;
  assign O_PDOWN     = s_q.pd;
  assign O_WDT_CLR   = s_q.wdt;
  assign O_ICYC      = !s_q.pd && s_q.ph == `MCX_PH_EXEC;

  // checks
  logic [`MCX_DW:0]   chk_sum;
  logic [`MCX_DW-1:0] chk_rlc;
  assign chk_sum = {1'b0, s_q.acc} + {1'b0, (imm_sel ? imm : s_q.md)};
  assign chk_rlc = {s_q.md[`MCX_DW-2:0], s_q.c};

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  sequence s_quiet3;
    !O_ICYC [*3];
  endsequence

  sequence s_second_cycle;
    s_q.stall [*4] ##1 !s_q.stall;
  endsequence

  a_cycle_period: assert property (
    O_ICYC && !s_d.pd |=> s_quiet3 ##1 O_ICYC)
    else $error("instruction cycle is not four clocks");

  a_one_cycle_step: assert property (
    ex && op == OP_XFER_AX |=> !s_q.stall && s_q.pc == $past(pc_inc))
    else $error("single-cycle op stalled or pc misstep");

  a_branch_two: assert property (
    ex && op inside {OP_JUMP, OP_CALL, OP_SUB_EXIT, OP_INT_EXIT}
    |=> s_second_cycle)
    else $error("branch did not take exactly two cycles");

  a_pc_low_write: assert property (
    ex && op == OP_XFER_MA && imm == `MCX_PC_LOW_ADDR
    |=> s_q.stall && !O_DM.we && s_q.pc[`MCX_DW-1:0] == $past(s_q.acc))
    else $error("low pc write not a jump");

  a_skip_taken: assert property (
    ex && skip |=> s_q.stall && s_q.pc == $past(s_q.pc) + `MCX_PC_INC2)
    else $error("taken skip wrong");

  a_skip_none: assert property (
    ex && is_skip(op) && !skip |=> !s_q.stall)
    else $error("untaken skip stalled");

  a_move_in: assert property (
    ex && op == OP_XFER_AM |=> s_q.acc == $past(s_q.md))
    else $error("move to acc wrong");

  a_add_carry: assert property (
    ex && op == OP_ADD
    |=> s_q.c == $past(chk_sum[`MCX_DW]))
    else $error("add carry wrong");

  a_inc_one: assert property (
    ex && op == OP_INC && imm != `MCX_PC_LOW_ADDR
    |=> (to_mem ? O_DM.wdata : s_q.acc) == $past(s_q.md) + `MCX_BIT_ONE)
    else $error("increment not by one");

  a_logic_zero: assert property (
    ex && op == OP_AND && !to_mem |=> s_q.z == (s_q.acc == '0))
    else $error("zero flag wrong");

  a_rot_carry: assert property (
    ex && op == OP_ROT && s_q.ir[`MCX_BIT_HI:`MCX_BIT_LO] == 3'h6
    |=> s_q.acc == $past(chk_rlc) && s_q.c == $past(s_q.md[`MCX_DW-1]))
    else $error("rotate through carry wrong");

  a_jump_target: assert property (
    ex && op == OP_JUMP
    |=> s_q.pc == $past(s_q.ir[`MCX_TGT_HI:0]) && $stable(s_q.sp))
    else $error("jump target or stack wrong");

  a_call_return: assert property (
    ex && op == OP_CALL
    |=> s_q.sp == $past(s_q.sp) + 1'b1 && top_ret == $past(pc_inc))
    else $error("call saved wrong address");

  a_exit_keeps_gie: assert property (
    ex && op == OP_SUB_EXIT
    |=> s_q.pc == $past(top_ret) && $stable(s_q.gie))
    else $error("plain exit wrong");

  a_int_exit_gie: assert property (
    ex && op == OP_INT_EXIT |=> s_q.gie && s_q.pc == $past(top_ret))
    else $error("interrupt exit did not enable");

  a_bit_only: assert property (
    ex && op == OP_SETB && imm != `MCX_PC_LOW_ADDR
    |=> O_DM.we && O_DM.wdata == ($past(s_q.md) | $past(bit_mask)))
    else $error("bit set touched other bits");

  a_table_write: assert property (
    ex && op == OP_TABRD && imm != `MCX_PC_LOW_ADDR
    |=> s_q.tab ##4 (O_DM.we && O_DM.wdata == s_q.tw[`MCX_DW-1:0]))
    else $error("table data not written");

  a_halt_sleep: assert property (
    ex && op == OP_HALT |=> O_PDOWN && !O_ICYC)
    else $error("power-down not entered");

endmodule

// ---- sim/mcx_mem_model.sv ----
`timescale 1ns/1ps
`include "mcx_params.svh"
module mcx_mem_model
  import mcx_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic [`MCX_PC_W-1:0] i_pm_addr,
  input  wire mcx_dm_req_t          i_dm,
  output      logic [`MCX_IW-1:0]   o_pm_data,
  output      logic [`MCX_DW-1:0]   o_dm_rdata
);
  logic [`MCX_IW-1:0] pm [2**`MCX_PC_W];
  logic [`MCX_DW-1:0] dm [2**`MCX_DW];

  // combinational read, well inside fetch and operand phases
  assign o_pm_data  = pm[i_pm_addr];
  assign o_dm_rdata = dm[i_dm.addr];

  always @(posedge i_sys_clk)
  begin
    if (i_dm.we === 1'b1)
    begin
      dm[i_dm.addr] <= i_dm.wdata;
    end
  end
endmodule

// ---- sim/mcu_instruction_execution_timing_bench.sv ----
`timescale 1ns/1ps
`include "mcx_params.svh"
module mcu_instruction_execution_timing_bench
  import mcx_pkg::*;
;
  logic                 sys_clk;
  logic                 arst_n;
  logic                 wake;
  logic [`MCX_IW-1:0]   pm_data;
  logic [`MCX_DW-1:0]   dm_rdata;
  logic [`MCX_PC_W-1:0] pm_addr;
  mcx_dm_req_t          dm_req;
  logic [`MCX_DW-1:0]   acc;
  logic [`MCX_DW-1:0]   tblh;
  logic                 zero;
  logic                 carry;
  logic                 gie;
  logic                 pdown;
  logic                 wdt_clr;
  logic                 icyc;
  int                   err_count;
  int                   n_compared;
  int                   wdt_n;

  mcx_core i_mcx_core (
    .I_SYS_CLK  (sys_clk),
    .I_ARST_N   (arst_n),
    .I_PM_DATA  (pm_data),
    .I_DM_RDATA (dm_rdata),
    .I_WAKE     (wake),
    .O_PM_ADDR  (pm_addr),
    .O_DM       (dm_req),
    .O_ACC      (acc),
    .O_TBLH     (tblh),
    .O_ZERO     (zero),
    .O_CARRY    (carry),
    .O_GIE      (gie),
    .O_PDOWN    (pdown),
    .O_WDT_CLR  (wdt_clr),
    .O_ICYC     (icyc)
  );

  mcx_mem_model i_mcx_mem_model (
    .i_sys_clk  (sys_clk),
    .i_pm_addr  (pm_addr),
    .i_dm       (dm_req),
    .o_pm_data  (pm_data),
    .o_dm_rdata (dm_rdata)
  );

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (wdt_clr === 1'b1)
      wdt_n++;
  end

  function automatic logic [15:0] w(input mcx_op_t op,
                                    input logic [2:0] mid,
                                    input logic [7:0] lo);
    return {op, mid, lo};
  endfunction

  function automatic logic [15:0] dmv(input logic [7:0] a);
    return 16'(i_mcx_mem_model.dm[a]);
  endfunction

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic put(input int a, input logic [15:0] d);
    i_mcx_mem_model.pm[a] = d;
  endtask

  task automatic clr;
    for (int i = 0; i < 2**`MCX_PC_W; i++) i_mcx_mem_model.pm[i] = 16'h0;
    for (int i = 0; i < 256; i++) i_mcx_mem_model.dm[i] = 8'h00;
  endtask

  task automatic rst;
    @(posedge sys_clk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(16'(pm_addr), 16'h0000);
    arst_n = 1'b1;
  endtask

  // wait for an address to be issued; t is the expected clock count
  task automatic go(input logic [10:0] a, input int t);
    int n;
    n = 0;
    while (pm_addr !== a && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      err_count++;
      $display("unexpected at %0t: address %h never issued", $time, a);
      wrap_up();
    end
    if (t > 0)
      chk(16'(n), 16'(t));
  endtask

  task automatic st(input logic [10:0] a, input int t, input logic [7:0] ea,
                    input logic ec, input logic ez);
    go(a, t);
    chk(16'(acc), 16'(ea));
    chk(16'(carry), 16'(ec));
    chk(16'(zero), 16'(ez));
  endtask

  task automatic t_arith;
    clr();
    put(0, w(OP_XFER_AX, 3'h2, 8'hf0));
    put(1, w(OP_ADD, 3'h2, 8'h20));
    put(2, w(OP_XFER_MA, 3'h0, 8'h60));
    put(3, w(OP_SUB, 3'h2, 8'h10));
    put(4, w(OP_SUB, 3'h2, 8'h01));
    put(5, w(OP_AND, 3'h2, 8'h00));
    put(6, w(OP_XFER_AM, 3'h0, 8'h60));
    put(7, w(OP_OR, 3'h2, 8'h03));
    put(8, w(OP_XOR, 3'h2, 8'h13));
    put(9, w(OP_COMPL, 3'h0, 8'h60));
    put(10, w(OP_SNZB, 3'h4, 8'h60));
    put(11, w(OP_XFER_AX, 3'h2, 8'h00));
    put(12, w(OP_SZB, 3'h4, 8'h60));
    put(13, w(OP_JUMP, 3'h0, 8'h0d));
    rst();
    st(11'h001, -1, 8'hf0, 1'b0, 1'b0);
    st(11'h002, 4, 8'h10, 1'b1, 1'b0);
    st(11'h003, 4, 8'h10, 1'b1, 1'b0);
    st(11'h004, 4, 8'h00, 1'b1, 1'b1);
    st(11'h005, 4, 8'hff, 1'b0, 1'b0);
    st(11'h006, 4, 8'h00, 1'b0, 1'b1);
    st(11'h007, 4, 8'h10, 1'b0, 1'b1);
    st(11'h008, 4, 8'h13, 1'b0, 1'b0);
    st(11'h009, 4, 8'h00, 1'b0, 1'b1);
    st(11'h00a, 4, 8'hef, 1'b0, 1'b0);
    go(11'h00c, 4);
    st(11'h00d, 8, 8'hef, 1'b0, 1'b0);
    chk(dmv(8'h60), 16'h0010);
    $display("arith test done");
  endtask

  task automatic t_flow;
    clr();
    i_mcx_mem_model.dm[8'h02] = 8'ha5;
    i_mcx_mem_model.dm[8'h42] = 8'h08;
    put(0, w(OP_CALL, 3'h0, 8'h10));
    put(1, w(OP_SZ, 3'h0, 8'h41));
    put(2, w(OP_XFER_AX, 3'h2, 8'h99));
    put(3, w(OP_SZ, 3'h0, 8'h42));
    put(4, w(OP_CALL, 3'h0, 8'h20));
    put(5, w(OP_XFER_AX, 3'h2, 8'h7c));
    put(6, w(OP_XFER_MA, 3'h0, 8'h02));
    put(16, w(OP_XFER_AX, 3'h2, 8'h55));
    put(17, w(OP_SUB_EXIT, 3'h0, 8'h00));
    put(32, w(OP_INT_EXIT, 3'h0, 8'h00));
    put(124, w(OP_JUMP, 3'h0, 8'h40));
    put(64, w(OP_JUMP, 3'h0, 8'h40));
    rst();
    go(11'h010, -1);
    go(11'h011, 8);
    go(11'h001, 4);
    chk(16'(acc), 16'h0055);
    chk(16'(gie), 16'h0000);
    go(11'h004, 16);
    chk(16'(acc), 16'h0055);
    go(11'h020, 4);
    go(11'h005, 8);
    chk(16'(gie), 16'h0001);
    go(11'h006, 8);
    go(11'h040, 12);
    chk(dmv(8'h02), 16'h00a5);
    $display("flow test done");
  endtask

  task automatic t_bits;
    logic [15:0] tw;
    clr();
    tw = w(OP_ROT, 3'h4, 8'h52);
    i_mcx_mem_model.dm[8'h50] = 8'h01;
    i_mcx_mem_model.dm[8'h51] = 8'h01;
    i_mcx_mem_model.dm[8'h52] = 8'h02;
    put(0, w(OP_SETB, 3'h7, 8'h50));
    put(1, w(OP_CLRB, 3'h0, 8'h50));
    put(2, w(OP_INC, 3'h1, 8'h50));
    put(3, w(OP_DEC, 3'h0, 8'h51));
    put(4, w(OP_ROT, 3'h6, 8'h50));
    put(5, tw);
    put(6, w(OP_ROT, 3'h3, 8'h52));
    put(7, w(OP_XFER_AX, 3'h2, 8'h05));
    put(8, w(OP_TABRD, 3'h0, 8'h53));
    put(9, w(OP_JUMP, 3'h0, 8'h09));
    rst();
    st(11'h001, -1, 8'h00, 1'b0, 1'b0);
    st(11'h002, 4, 8'h00, 1'b0, 1'b0);
    st(11'h003, 4, 8'h00, 1'b0, 1'b0);
    chk(dmv(8'h50), 16'h0080);
    st(11'h004, 4, 8'h00, 1'b0, 1'b1);
    st(11'h005, 4, 8'h02, 1'b1, 1'b1);
    st(11'h006, 4, 8'h81, 1'b0, 1'b1);
    st(11'h007, 4, 8'h81, 1'b0, 1'b1);
    st(11'h008, 4, 8'h05, 1'b0, 1'b1);
    go(11'h009, -1);
    repeat (11) @(posedge sys_clk);
    #1;
    chk(16'(icyc), 16'h0001);
    chk(dmv(8'h50), 16'h0081);
    chk(dmv(8'h51), 16'h0001);
    chk(dmv(8'h52), 16'h0004);
    chk(dmv(8'h53), 16'(tw[7:0]));
    chk(16'(tblh), 16'(tw[15:8]));
    $display("bits test done");
  endtask

  task automatic t_halt;
    int n;
    int w0;
    clr();
    put(0, w(OP_CLRWDT, 3'h0, 8'h00));
    put(1, w(OP_HALT, 3'h0, 8'h00));
    put(2, w(OP_XFER_AX, 3'h2, 8'h3c));
    put(3, w(OP_JUMP, 3'h0, 8'h03));
    rst();
    w0 = wdt_n;
    go(11'h002, -1);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(16'(pdown), 16'h0001);
    chk(16'(pm_addr), 16'h0002);
    chk(16'(acc), 16'h0000);
    chk(16'(icyc), 16'h0000);
    wake = 1'b1;
    n = 0;
    while (pdown !== 1'b0 && n < 12)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(16'(pdown), 16'h0000);
    go(11'h003, -1);
    chk(16'(acc), 16'h003c);
    chk(16'(wdt_n - w0), 16'h0001);
    wake = 1'b0;
    $display("halt test done");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    wake = 1'b0;
    err_count = 0;
    n_compared = 0;
    wdt_n = 0;
    t_arith();
    t_flow();
    t_bits();
    t_halt();
    wrap_up();
  end
endmodule
